// ==== verification/ldo_channel_control_regs_test.sv ====
/* Bench for the regulator register bank: random writes and reads.
 Assumes the one-cycle read latency of the register port. */
`timescale 1ns/10ps
`include "ldo_regs_consts.vh"
`define CHK(g,e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module ldo_channel_control_regs_test;
  reg c = 0, r = 0, we = 0, re = 0, rs = 0;
  reg [7:0] ad = 0, wd = 0, d, b;
  reg [1:0] pg = 0, ft = 0;
  reg [8:0] q[$];
  reg [8:0] n;
  reg [2:0] x;
  wire [7:0] rd;
  wire [5:0] la, lb;
  wire hit, ea, eb, da, db, ia, ib;
  int fail_count = 0, checks_done = 0, cyc = 0, i;
  ldo_channel_control_regs uut (.core_clk_in(c), .rst_n_in(r),
    .addr_in(ad), .wr_en_in(we), .wdata_in(wd), .rd_en_in(re),
    .rdata_out(rd), .rd_hit_out(hit), .a_power_good_in(pg[0]),
    .a_fault_in(ft[0]), .a_output_level_code_out(la), .a_enable_out(ea),
    .a_output_bleed_enable_out(da), .a_fault_irq_out(ia),
    .b_power_good_in(pg[1]), .b_fault_in(ft[1]),
    .b_output_level_code_out(lb), .b_enable_out(eb),
    .b_output_bleed_enable_out(db), .b_fault_irq_out(ib));
  initial forever #10 c = ~c;
  task finish_test;
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reads leave a note of {hit, data}; one idle cycle follows each access
  task acc(input w, input [7:0] a, v, input [8:0] e);
    @(negedge c);
    ad = a; wd = v; we = w; re = !w;
    if (!w) q.push_back(e);
    @(negedge c);
    we = 0; re = 0;
  endtask
  // Every output sits at its reset value while reset is held
  task chk_rst;
    `CHK({rd, hit, la, lb, ea, eb, da, db, ia, ib}, 27'h0)
  endtask
  always @(posedge c) rs <= re;
  // The macro reads its arguments twice, so the note is popped first
  always @(negedge c) if (rs) begin
    n = q.pop_front();
    `CHK({hit, rd}, n)
  end
  always @(posedge c) if (++cyc > 3000) begin fail_count++; finish_test; end
  initial begin
    void'($urandom(32'h58f5));
    repeat (16) @(negedge c);
    chk_rst;
    r = 1;
    acc(0, `OFF_A_CONTROL, 0, 9'h100);
    acc(0, 8'h52, 0, 9'h000);
    ft = 2'h3;
    acc(1, `OFF_A_CONTROL, 8'h06, 0);
    `CHK({ea, da, ia}, 3'h3)
    acc(1, `OFF_A_CONTROL, 8'h84, 0);
    `CHK({ea, da, ia}, 3'h4)
    for (i = 0; i < 16; i++) begin
      b = i[0] ? `OFF_B_LEVEL : `OFF_A_LEVEL;
      d = 8'($urandom); pg = 2'($urandom); ft = 2'($urandom);
      acc(1, b, d, 0);
      // Unmapped write must not disturb the level just written
      acc(1, 8'h5a, ~d, 0);
      `CHK(i[0] ? lb : la, d[5:0])
      acc(0, b, 0, {3'h4, d[5:0]});
      acc(1, b + 8'h01, d, 0);
      x = {d[7], d[2] & !d[7], d[1] & ft[i[0]]};
      `CHK(i[0] ? {eb, db, ib} : {ea, da, ia}, x)
      acc(0, b + 8'h01, ~d, {1'b1, d[7], 4'h0, d[2:1], pg[i[0]]});
    end
    // A reset in mid-run must clear every written field again
    r = 0;
    @(negedge c);
    chk_rst;
    r = 1;
    acc(0, `OFF_B_CONTROL, 0, {1'b1, 7'h00, pg[1]});
    // Let the read monitor take the last note before the queue is checked
    @(negedge c);
    `CHK(q.size(), 0)
    finish_test;
  end
endmodule

// ==== verification/ldo_regs_properties.sv ====
/* Port checker for the regulator register bank.
 Bound onto the top module; sees only its ports. */
`timescale 1ns/10ps
`include "ldo_regs_consts.vh"
module ldo_regs_properties (
  input wire core_clk_in, rst_n_in, wr_en_in, rd_en_in, rd_hit_out,
  input wire [7:0] addr_in, wdata_in, rdata_out,
  input wire a_power_good_in, a_fault_in, a_enable_out, a_fault_irq_out,
  input wire a_output_bleed_enable_out,
  input wire [5:0] a_output_level_code_out, b_output_level_code_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_on;
    wr_en_in && addr_in == `OFF_A_CONTROL |=>
      a_enable_out == $past(wdata_in[7]);
  endproperty
  a_on: assert property (p_on) else $error("enable");
  property p_bleed;
    a_output_bleed_enable_out |-> !a_enable_out;
  endproperty
  a_bleed: assert property (p_bleed) else $error("bleed");
  property p_bleed_wr;
    wr_en_in && addr_in == `OFF_A_CONTROL |=>
      a_output_bleed_enable_out == ($past(wdata_in[2]) && !$past(wdata_in[7]));
  endproperty
  a_bleed_wr: assert property (p_bleed_wr) else $error("bleed write");
  property p_irq;
    a_fault_irq_out |-> a_fault_in;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_irq_wr;
    wr_en_in && addr_in == `OFF_A_CONTROL |=>
      a_fault_irq_out == (a_fault_in && $past(wdata_in[1]));
  endproperty
  a_irq_wr: assert property (p_irq_wr) else $error("irq gate");
  property p_pg;
    rd_en_in && addr_in == `OFF_A_CONTROL |=>
      rdata_out[0] == $past(a_power_good_in);
  endproperty
  a_pg: assert property (p_pg) else $error("power good");
  property p_lvl;
    wr_en_in && addr_in == `OFF_A_LEVEL |=>
      a_output_level_code_out == $past(wdata_in[5:0]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level a");
  property p_lvlb;
    wr_en_in && addr_in == `OFF_B_LEVEL |=>
      b_output_level_code_out == $past(wdata_in[5:0]);
  endproperty
  a_lvlb: assert property (p_lvlb) else $error("level b");
  property p_rsv;
    rd_en_in && addr_in == `OFF_A_LEVEL |=>
      rd_hit_out && rdata_out[7:6] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_rsv_ctl;
    rd_en_in && addr_in == `OFF_A_CONTROL |=>
      rd_hit_out && rdata_out[6:3] == 4'h0;
  endproperty
  a_rsv_ctl: assert property (p_rsv_ctl) else $error("reserved ctl");
endmodule
bind ldo_channel_control_regs ldo_regs_properties chk (.*);

// ==== verilog/ldo_channel.v ====
/*
 One regulator channel: level code, enable, bleed option and fault
 permission held in flip-flops, plus the control outputs toward the
 analog core. Assumes the register port decode sits in the parent.
*/
`timescale 1ns/10ps
`include "ldo_regs_consts.vh"

module ldo_channel #(
  parameter LEVEL_W = `LEVEL_W
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Write strobes from the parent decode
  input wire level_we_in,
  input wire control_we_in,
  input wire [`DATA_W-1:0] wdata_in,
  // Analog core status
  input wire power_good_in,
  input wire fault_in,
  // Analog core control
  output wire [LEVEL_W-1:0] output_level_code_out,
  output wire enable_out,
  output wire output_bleed_enable_out,
  output wire fault_irq_out,
  // Readback
  output wire [`DATA_W-1:0] level_rdata_out,
  output wire [`DATA_W-1:0] control_rdata_out
);

  reg [LEVEL_W-1:0] level_ff;
  reg enable_ff;
  reg bleed_ff;
  reg fault_allow_ff;

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      level_ff <= `RST_LEVEL;
      enable_ff <= `RST_BIT;
      bleed_ff <= `RST_BIT;
      fault_allow_ff <= `RST_BIT;
    end else begin
      if (level_we_in) begin
        level_ff <= wdata_in[LEVEL_W-1:0];
      end
      // power-good bit is not stored, writes to it drop
      if (control_we_in) begin
        enable_ff <= wdata_in[`BIT_ENABLE];
        bleed_ff <= wdata_in[`BIT_BLEED];
        fault_allow_ff <= wdata_in[`BIT_FAULT_ALLOW];
      end
    end
  end

  assign output_level_code_out = level_ff;
  assign enable_out = enable_ff;
  assign output_bleed_enable_out = bleed_ff & ~enable_ff;
  assign fault_irq_out = fault_in & fault_allow_ff;

  assign level_rdata_out = {{(`DATA_W-LEVEL_W){1'b0}}, level_ff};
  assign control_rdata_out = {enable_ff, 4'h0, bleed_ff, fault_allow_ff,
                              power_good_in};

endmodule

// ==== verilog/ldo_channel_control_regs.v ====
/*
 Register bank for two linear-regulator channels. The host reaches the
 four registers through a simple synchronous address/write/read port
 supplied by the device's serial bus front end (not in this block).
 Assumes power-good and fault levels are synchronous to core_clk_in.
*/
`timescale 1ns/10ps
`include "ldo_regs_consts.vh"

// Function
// - Channel A regulator is on while its enable bit is one.
// - Bleed control asserts when bleed bit set and channel is shut down.
// - Channel fault raises interrupt only while fault-allow bit is one.
// - Power-good bit reads live comparator state; writes ignored.
// - Six-bit level code held at 0x50 and driven to the core.
// - Channel B repeats the layout at 0x58 and 0x59.
module ldo_channel_control_regs #(
  parameter LEVEL_W = `LEVEL_W
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Register port
  input wire [`ADDR_W-1:0] addr_in,
  input wire wr_en_in,
  input wire [`DATA_W-1:0] wdata_in,
  input wire rd_en_in,
  output reg [`DATA_W-1:0] rdata_out,
  output reg rd_hit_out,
  // Channel A core
  input wire a_power_good_in,
  input wire a_fault_in,
  output wire [LEVEL_W-1:0] a_output_level_code_out,
  output wire a_enable_out,
  output wire a_output_bleed_enable_out,
  output wire a_fault_irq_out,
  // Channel B core
  input wire b_power_good_in,
  input wire b_fault_in,
  output wire [LEVEL_W-1:0] b_output_level_code_out,
  output wire b_enable_out,
  output wire b_output_bleed_enable_out,
  output wire b_fault_irq_out
);

  wire [`DATA_W-1:0] a_level_rd;
  wire [`DATA_W-1:0] a_control_rd;
  wire [`DATA_W-1:0] b_level_rd;
  wire [`DATA_W-1:0] b_control_rd;
  reg [`DATA_W-1:0] nxt_rdata;
  reg nxt_hit;

  ldo_channel #(.LEVEL_W(LEVEL_W)) u_ldo_channel_a (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .level_we_in(wr_en_in && addr_in == `OFF_A_LEVEL),
    .control_we_in(wr_en_in && addr_in == `OFF_A_CONTROL),
    .wdata_in(wdata_in),
    .power_good_in(a_power_good_in),
    .fault_in(a_fault_in),
    .output_level_code_out(a_output_level_code_out),
    .enable_out(a_enable_out),
    .output_bleed_enable_out(a_output_bleed_enable_out),
    .fault_irq_out(a_fault_irq_out),
    .level_rdata_out(a_level_rd),
    .control_rdata_out(a_control_rd)
  );

  ldo_channel #(.LEVEL_W(LEVEL_W)) u_ldo_channel_b (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .level_we_in(wr_en_in && addr_in == `OFF_B_LEVEL),
    .control_we_in(wr_en_in && addr_in == `OFF_B_CONTROL),
    .wdata_in(wdata_in),
    .power_good_in(b_power_good_in),
    .fault_in(b_fault_in),
    .output_level_code_out(b_output_level_code_out),
    .enable_out(b_enable_out),
    .output_bleed_enable_out(b_output_bleed_enable_out),
    .fault_irq_out(b_fault_irq_out),
    .level_rdata_out(b_level_rd),
    .control_rdata_out(b_control_rd)
  );

  // Unmapped addresses read zero with no hit flag
  always @* begin
    nxt_rdata = {`DATA_W{1'b0}};
    nxt_hit = 1'b1;
    case (addr_in)
      `OFF_A_LEVEL: nxt_rdata = a_level_rd;
      `OFF_A_CONTROL: nxt_rdata = a_control_rd;
      `OFF_B_LEVEL: nxt_rdata = b_level_rd;
      `OFF_B_CONTROL: nxt_rdata = b_control_rd;
      default: nxt_hit = 1'b0;
    endcase
  end

  // Read data is registered so it holds until the next read
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= {`DATA_W{1'b0}};
      rd_hit_out <= 1'b0;
    end else if (rd_en_in) begin
      rdata_out <= nxt_rdata;
      rd_hit_out <= nxt_hit;
    end
  end

endmodule

// ==== verilog/ldo_regs_consts.vh ====
/*
 Constants for the two-channel regulator control register bank:
 register offsets, field positions and field widths.
 Assumes inclusion by bare name from the design files.
*/
`ifndef LDO_REGS_CONSTS_VH
`define LDO_REGS_CONSTS_VH

`define ADDR_W 8
`define DATA_W 8
`define LEVEL_W 6

`define OFF_A_LEVEL 8'h50
`define OFF_A_CONTROL 8'h51
`define OFF_B_LEVEL 8'h58
`define OFF_B_CONTROL 8'h59

`define BIT_ENABLE 7
`define BIT_BLEED 2
`define BIT_FAULT_ALLOW 1
`define BIT_POWER_GOOD 0

`define RST_LEVEL 6'h00
`define RST_BIT 1'b0

`endif
